// ### rtl/pbr_pkg.sv
// pbr_pkg: constants for the port buffer and read-back block
// assumes: nothing beyond a SystemVerilog compiler
package pbr_pkg;
    // ============================================================
    // widths and counts
    localparam int PBR_OUT_PORTS   = 4;      // pure output ports
    localparam int PBR_BIDIR_PORTS = 3;      // bidirectional ports
    localparam int PBR_PORT_W      = 4;      // bits per port
    localparam int PBR_OUT3_IDX    = 3;      // output port three
    localparam int PBR_BIDIR2_IDX  = 2;      // bidirectional port two
    localparam int PBR_OUT_BITS    = PBR_OUT_PORTS * PBR_PORT_W;
    localparam int PBR_BIO_BITS    = PBR_BIDIR_PORTS * PBR_PORT_W;
    localparam int PBR_SEL_W       = 2;

    // ============================================================
    // pin timing: least low width in basic clock cycles
    localparam int PBR_MIN_LOW_CYC = 4;
    localparam int PBR_CNT_W       = 3;
    localparam logic [PBR_CNT_W-1:0] PBR_CNT_ZERO = 3'h0;
    localparam logic [PBR_CNT_W-1:0] PBR_CNT_ONE  = 3'h1;

    // ============================================================
    // reset values and buffer variants
    localparam logic PBR_LATCH_RST   = 1'h1; // latches set to one
    localparam logic PBR_BUF_OD      = 1'h0; // variant (A): open drain
    localparam logic PBR_BUF_PULLUP  = 1'h1; // variant (B): pull-up
    localparam logic PBR_PIN_IDLE    = 1'h1; // pulled-up inactive level
    localparam logic [PBR_OUT_BITS-1:0] PBR_OUT_ONES = 16'hFFFF;
    localparam logic [PBR_BIO_BITS-1:0] PBR_BIO_ONES = 12'hFFF;
    localparam logic [2:0] PBR_SYNC_IDLE = 3'h7;
endpackage : pbr_pkg

// ### rtl/pbr_pin_if.sv
// pbr_pin_if: pin-low level and qualified flag between core and low-width filter
// assumes: one clock domain
`timescale 1ns/1ps
`default_nettype none
interface pbr_pin_if;
    logic pin_low;    // synchronised pin level is low
    logic qualified;  // low for at least the minimum width
    modport core   (input  qualified, output pin_low);
    modport filter (output qualified, input  pin_low);
endinterface : pbr_pin_if
`default_nettype wire

// ### rtl/pbr_low_filter.sv
// pbr_low_filter: qualifies an active-low pin held for a minimum width
// assumes: pin_low already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
module pbr_low_filter
    import pbr_pkg::*;
#(
    parameter int MIN_CYC = PBR_MIN_LOW_CYC
) (
    input  wire logic clock,
    input  wire logic arst_n,
    pbr_pin_if.filter pin
);
    typedef struct packed {
        logic [PBR_CNT_W-1:0] cnt;
        logic                 qual;
    } pbr_flt_type;

    pbr_flt_type st_r;
    pbr_flt_type st_nxt;

    initial begin
        if (MIN_CYC < 1 || MIN_CYC >= (1 << PBR_CNT_W))
            $error("pbr_low_filter: MIN_CYC out of range");
    end

    // ============================================================
    // count consecutive low cycles, qualify at the minimum
    always_comb begin
        st_nxt = st_r;
        if (!pin.pin_low) begin
            st_nxt.cnt  = PBR_CNT_ZERO;
            st_nxt.qual = 1'b0;
        end else if (st_r.cnt < PBR_CNT_W'(MIN_CYC)) begin
            st_nxt.cnt  = st_r.cnt + PBR_CNT_ONE;
            st_nxt.qual = (st_r.cnt + PBR_CNT_ONE) == PBR_CNT_W'(MIN_CYC);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin.qualified = st_r.qual;
endmodule : pbr_low_filter
`default_nettype wire

// ### rtl/pbr_port_buffer.sv
// pbr_port_buffer: output latches, bidirectional drivers and read-back
// assumes: a core writes ports by strobe and reads them back by index;
// pin inputs arrive asynchronously and pass three flip-flops here
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: buffer variant fixed per bit by parameter
// R2: software writes one before reading bidirectional
// R3: evaluator forces all bits open drain
// R4: reset and interrupt pins weakly pulled high
// R5: output port reads return latch value
// R6: bidirectional port reads return sampled pin
// R7: evaluator maps output three onto bidir two
// R8: interrupt request needs four low cycles
// R9: reset request needs four low cycles
// R10: initialisation sets every output latch one
// R11: bidirectional read is latch and pin wired
module pbr_port_buffer
    import pbr_pkg::*;
#(
    parameter logic [PBR_OUT_BITS-1:0] OUT_PULLUP_MASK = '0,
    parameter logic [PBR_BIO_BITS-1:0] BIO_PULLUP_MASK = '0,
    parameter bit                      EVALUATOR       = 1'b0,
    parameter int                      MIN_LOW_CYC     = PBR_MIN_LOW_CYC
) (
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    input  wire logic                          out_wr,
    input  wire logic [PBR_SEL_W-1:0]          out_sel,
    input  wire logic [PBR_PORT_W-1:0]         out_wdata,
    input  wire logic                          bio_wr,
    input  wire logic [PBR_SEL_W-1:0]          bio_sel,
    input  wire logic [PBR_PORT_W-1:0]         bio_wdata,
    input  wire logic [PBR_SEL_W-1:0]          out_rsel,
    output logic      [PBR_PORT_W-1:0]         out_rdata,
    input  wire logic [PBR_SEL_W-1:0]          bio_rsel,
    output logic      [PBR_PORT_W-1:0]         bio_rdata,
    output logic      [PBR_OUT_BITS-1:0]       out_pin_o,
    output logic      [PBR_OUT_BITS-1:0]       out_pin_oe,
    output logic      [PBR_OUT_BITS-1:0]       out_pin_pullup,
    input  wire logic [PBR_BIO_BITS-1:0]       bio_pin_i,
    output logic      [PBR_BIO_BITS-1:0]       bio_pin_o,
    output logic      [PBR_BIO_BITS-1:0]       bio_pin_oe,
    output logic      [PBR_BIO_BITS-1:0]       bio_pin_pullup,
    input  wire logic                          rst_pin_n,
    input  wire logic                          int_pin_n,
    output logic                               ctl_pin_pullup,
    output logic                               reset_req,
    output logic                               int_req
);
    // ============================================================
    // state
    // out_latch and bio_latch hold what software last wrote;
    // bio_s1..s3 are the three-stage synchroniser on the pins,
    // bio_pin the agreed level that the read path uses;
    // out_rd and bio_rd register the read data so that the
    // read ports never glitch while a pin is settling
    typedef struct packed {
        logic [PBR_OUT_BITS-1:0] out_latch;
        logic [PBR_BIO_BITS-1:0] bio_latch;
        logic [PBR_BIO_BITS-1:0] bio_s1;
        logic [PBR_BIO_BITS-1:0] bio_s2;
        logic [PBR_BIO_BITS-1:0] bio_s3;
        logic [PBR_BIO_BITS-1:0] bio_pin;
        logic [2:0]              rst_sync;
        logic [2:0]              int_sync;
        logic                    rst_low;
        logic                    int_low;
        logic [PBR_PORT_W-1:0]   out_rd;
        logic [PBR_PORT_W-1:0]   bio_rd;
        logic                    int_armed;
        logic                    int_req;
    } pbr_state_type;

    pbr_state_type st_r;
    pbr_state_type st_nxt;

    pbr_pin_if rst_if ();
    pbr_pin_if int_if ();

    // the filter counter is PBR_CNT_W bits wide, so the minimum
    // width must fit it and be at least one cycle
    initial begin
        if (MIN_LOW_CYC < 1 || MIN_LOW_CYC >= (1 << PBR_CNT_W))
            $error("pbr_port_buffer: MIN_LOW_CYC out of range");
    end

    // variant (A) is open drain; variant (B) adds a weak pull-up on
    // the bits of the mask. the choice is fixed at build time, so no
    // register can change it; the evaluator has no port pull-ups at all
    // variant per bit; evaluator always open drain
    localparam logic [PBR_OUT_BITS-1:0] OUT_PU =
        EVALUATOR ? '0 : OUT_PULLUP_MASK; // R1 R3
    localparam logic [PBR_BIO_BITS-1:0] BIO_PU =
        EVALUATOR ? '0 : BIO_PULLUP_MASK; // R1 R3

    // ============================================================
    // port slicing helpers
    function automatic logic [PBR_PORT_W-1:0] nib16(
        input logic [PBR_OUT_BITS-1:0] v, input logic [PBR_SEL_W-1:0] s);
        nib16 = v[s*PBR_PORT_W +: PBR_PORT_W];
    endfunction

    function automatic logic [PBR_PORT_W-1:0] nib12(
        input logic [PBR_BIO_BITS-1:0] v, input logic [PBR_SEL_W-1:0] s);
        if (int'(s) < PBR_BIDIR_PORTS)
            nib12 = v[s*PBR_PORT_W +: PBR_PORT_W];
        else
            nib12 = '0;
    endfunction

    // ============================================================
    // low-width qualification of reset and interrupt pins
    assign rst_if.pin_low = st_r.rst_low;
    assign int_if.pin_low = st_r.int_low;

    pbr_low_filter #(.MIN_CYC(MIN_LOW_CYC)) u_rst_flt (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (rst_if.filter)
    );

    pbr_low_filter #(.MIN_CYC(MIN_LOW_CYC)) u_int_flt (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (int_if.filter)
    );

    // ============================================================
    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // three-stage synchronisers; change counts when 2 and 3 agree
        st_nxt.bio_s1   = bio_pin_i;
        st_nxt.bio_s2   = st_r.bio_s1;
        st_nxt.bio_s3   = st_r.bio_s2;
        for (int i = 0; i < PBR_BIO_BITS; i++) begin
            if (st_r.bio_s2[i] == st_r.bio_s3[i])
                st_nxt.bio_pin[i] = st_r.bio_s3[i];
        end
        st_nxt.rst_sync = {st_r.rst_sync[1:0], rst_pin_n};
        st_nxt.int_sync = {st_r.int_sync[1:0], int_pin_n};
        if (st_r.rst_sync[1] == st_r.rst_sync[2])
            st_nxt.rst_low = !st_r.rst_sync[2];
        if (st_r.int_sync[1] == st_r.int_sync[2])
            st_nxt.int_low = !st_r.int_sync[2];

        // latch writes; a qualified reset pin re-initialises
        // writes are refused while the reset request stands
        if (rst_if.qualified) begin                           // R9
            st_nxt.out_latch = PBR_OUT_ONES;                  // R10
            st_nxt.bio_latch = PBR_BIO_ONES;                  // R10
        end else begin
            if (out_wr)
                st_nxt.out_latch[out_sel*PBR_PORT_W +: PBR_PORT_W] =
                    out_wdata;
            if (bio_wr && int'(bio_sel) < PBR_BIDIR_PORTS)
                st_nxt.bio_latch[bio_sel*PBR_PORT_W +: PBR_PORT_W] =
                    bio_wdata;
        end

        // read-back: latch for outputs, wired pin for bidirectionals
        // a clamp on a bidirectional pin shows up in the read data,
        // while an output port always reads its latch; on the
        // evaluator output port three is wired through bidirectional
        // port two, so its read follows that pin
        st_nxt.out_rd = nib16(st_r.out_latch, out_rsel);       // R5
        if (EVALUATOR && int'(out_rsel) == PBR_OUT3_IDX)
            st_nxt.out_rd = nib12(st_r.bio_pin & st_r.bio_latch,
                                  PBR_SEL_W'(PBR_BIDIR2_IDX)); // R7
        st_nxt.bio_rd = nib12(st_r.bio_pin & st_r.bio_latch,
                              bio_rsel);                       // R6 R11

        // one request per low pulse; re-arm once pin returns high
        // a held-low pin gives one request only; the pin must be seen
        // high again before another low pulse can raise a new one
        st_nxt.int_req = 1'b0;
        if (!st_r.int_low)
            st_nxt.int_armed = 1'b1;
        else if (int_if.qualified && st_r.int_armed) begin    // R8
            st_nxt.int_req   = 1'b1;
            st_nxt.int_armed = 1'b0;
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r           <= '0;
            st_r.out_latch <= PBR_OUT_ONES;                   // R10
            st_r.bio_latch <= PBR_BIO_ONES;                   // R10
            st_r.bio_s1    <= PBR_BIO_ONES;
            st_r.bio_s2    <= PBR_BIO_ONES;
            st_r.bio_s3    <= PBR_BIO_ONES;
            st_r.bio_pin   <= PBR_BIO_ONES;
            st_r.rst_sync  <= PBR_SYNC_IDLE;
            st_r.int_sync  <= PBR_SYNC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // pin drive: low when latch is zero, pull-up or release otherwise
    // no pin is ever driven high: a one releases the pin and leaves
    // the level to the pull-up, so an external circuit may pull low
    always_comb begin
        out_pin_o      = st_r.out_latch & OUT_PU;
        out_pin_oe     = ~st_r.out_latch;                     // R1
        out_pin_pullup = OUT_PU & st_r.out_latch;
        bio_pin_o      = '0;
        bio_pin_oe     = ~st_r.bio_latch;                     // R1 R3
        bio_pin_pullup = BIO_PU & st_r.bio_latch;
    end

    assign ctl_pin_pullup = PBR_PIN_IDLE;                     // R4
    assign reset_req      = rst_if.qualified;
    assign int_req        = st_r.int_req;
    assign out_rdata      = st_r.out_rd;
    assign bio_rdata      = st_r.bio_rd;
endmodule : pbr_port_buffer
`default_nettype wire

// ### verification/pbr_board_model.sv
// board circuit on the bidirectional pins: pull-up plus optional clamps
// assumes: device drives low only, never high
`timescale 1ns/1ps
`default_nettype none
module pbr_board_model (
    input  wire logic [pbr_pkg::PBR_BIO_BITS-1:0] bio_pin_oe,
    input  wire logic [pbr_pkg::PBR_BIO_BITS-1:0] clamp_low,
    output logic      [pbr_pkg::PBR_BIO_BITS-1:0] bio_pin_i
);
    // wired level: low when device or clamp pulls low, else pulled high
    assign bio_pin_i = ~(bio_pin_oe | clamp_low);
endmodule // pbr_board_model
`default_nettype wire

// ### verification/pbr_port_buffer_monitor.sv
// checker on the port buffer top-level ports
// assumes: bound to every pbr_port_buffer instance
`timescale 1ns/1ps
`default_nettype none
module pbr_port_buffer_monitor #(
    parameter bit EVALUATOR = 1'b0
) (
    input wire logic                          clock,
    input wire logic                          arst_n,
    input wire logic                          out_wr,
    input wire logic [pbr_pkg::PBR_SEL_W-1:0] out_sel,
    input wire logic [pbr_pkg::PBR_PORT_W-1:0] out_wdata,
    input wire logic                          bio_wr,
    input wire logic [pbr_pkg::PBR_SEL_W-1:0] out_rsel,
    input wire logic [pbr_pkg::PBR_PORT_W-1:0] out_rdata,
    input wire logic [pbr_pkg::PBR_SEL_W-1:0] bio_rsel,
    input wire logic [pbr_pkg::PBR_PORT_W-1:0] bio_rdata,
    input wire logic [pbr_pkg::PBR_OUT_BITS-1:0] out_pin_o,
    input wire logic [pbr_pkg::PBR_OUT_BITS-1:0] out_pin_oe,
    input wire logic [pbr_pkg::PBR_OUT_BITS-1:0] out_pin_pullup,
    input wire logic [pbr_pkg::PBR_BIO_BITS-1:0] bio_pin_o,
    input wire logic [pbr_pkg::PBR_BIO_BITS-1:0] bio_pin_oe,
    input wire logic [pbr_pkg::PBR_BIO_BITS-1:0] bio_pin_pullup,
    input wire logic                          rst_pin_n,
    input wire logic                          ctl_pin_pullup,
    input wire logic                          reset_req,
    input wire logic                          int_req
);
    import pbr_pkg::*;
    // ============================================================
    // sequences
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_rst_held;
        $fell(rst_pin_n) ##1 !rst_pin_n [*8];
    endsequence
    sequence s_rst_blip;
        !reset_req && $fell(rst_pin_n) ##1 !rst_pin_n ##1 rst_pin_n;
    endsequence
    // ============================================================
    // assertions
    a_ctl_pullup: assert property (ctl_pin_pullup)
        else $error("control pin pull-up off");
    a_od_forced: assert property (EVALUATOR |->
        (out_pin_o | out_pin_pullup | bio_pin_pullup | bio_pin_o) == 0)
        else $error("pin driven high on evaluator");
    a_out_write: assert property (out_wr && !reset_req |=>
        out_pin_oe[$past(out_sel)*4 +: 4] == ~$past(out_wdata))
        else $error("output latch write lost");
    a_out_read: assert property (out_rsel != 2'h3 && !out_wr
        && !$past(out_wr) && !reset_req |=>
        out_rdata == ~$past(out_pin_oe[out_rsel*4 +: 4]))
        else $error("output read not latch");
    a_bio_wired: assert property (bio_rsel != 2'h3 && !bio_wr
        && !$past(bio_wr) |=>
        (bio_rdata & $past(bio_pin_oe[bio_rsel*4 +: 4])) == 0)
        else $error("driven-low bit read high");
    a_out3_mirror: assert property (EVALUATOR && out_rsel == 2'h3
        && bio_rsel == 2'h2 |=> out_rdata == bio_rdata)
        else $error("output three not via bidir two");
    a_reset_clear: assert property (reset_req [*2] |->
        out_pin_oe == 0 && bio_pin_oe == 0)
        else $error("latches not set during reset");
    a_int_single: assert property (int_req |=> !int_req)
        else $error("interrupt pulse too long");
    a_rst_qualify: assert property (s_rst_held |-> ##[0:4] reset_req)
        else $error("held reset pin not taken");
    a_rst_short: assert property (s_rst_blip |-> !reset_req [*8])
        else $error("short reset pulse taken");
endmodule // pbr_port_buffer_monitor
bind pbr_port_buffer pbr_port_buffer_monitor
    #(.EVALUATOR(EVALUATOR)) i_mon (.*);
`default_nettype wire

// ### verification/tb_port_buffer_readback.sv
// self-checking bench for the port buffer in evaluator and production forms
// assumes: board model on the bidirectional pins
`timescale 1ns/1ps
`default_nettype none
module tb_port_buffer_readback;
    import pbr_pkg::*;
    logic        clock, arst_n, out_wr, bio_wr, rst_pin_n, int_pin_n;
    logic [1:0]  out_sel, bio_sel, out_rsel, bio_rsel;
    logic [3:0]  out_wdata, bio_wdata, out_rdata, bio_rdata;
    logic [15:0] out_pin_oe, out_pin_pullup;
    logic [11:0] bio_pin_i, bio_pin_o, bio_pin_oe, bio_pin_pullup, clamp;
    logic        ctl_pin_pullup, reset_req, int_req;
    // outputs of the production form (pull-up variant, no evaluator)
    logic [15:0] b_out_pin_o, b_out_pin_pullup;
    logic [11:0] b_bio_pin_pullup;
    logic [3:0]  b_out_rdata;
    int          n_mismatch, compares, k;
    // rows: sel, data, clamp, expected output read, expected bidir read
    logic [19:0] rows [4] = '{20'h0A0AA, 20'h1F5FA, 20'h23132, 20'h00000};
    pbr_port_buffer #(.OUT_PULLUP_MASK(16'h00FF),
        .BIO_PULLUP_MASK(12'h0F0), .EVALUATOR(1'b1))
        i_dut (.out_pin_o(), .*);
    pbr_port_buffer #(.OUT_PULLUP_MASK(16'h00FF),
        .BIO_PULLUP_MASK(12'h0F0), .EVALUATOR(1'b0))
        i_dut_b (.out_pin_o(b_out_pin_o), .out_pin_pullup(b_out_pin_pullup),
        .bio_pin_pullup(b_bio_pin_pullup), .out_rdata(b_out_rdata),
        .bio_rdata(), .out_pin_oe(), .bio_pin_o(), .bio_pin_oe(),
        .ctl_pin_pullup(), .reset_req(), .int_req(), .*);
    pbr_board_model i_board (.bio_pin_oe(bio_pin_oe), .clamp_low(clamp),
        .bio_pin_i(bio_pin_i));
    // ============================================================
    // helpers
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cnt_int(input int n);
        repeat (n) begin
            cyc(1);
            if (int_req === 1'b1) k++;
        end
    endtask
    task automatic finish_test;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ============================================================
    // main sequence
    initial begin
        {out_wr, bio_wr, out_sel, bio_sel, out_rsel, bio_rsel} = '0;
        {out_wdata, bio_wdata, clamp} = '0;
        {rst_pin_n, int_pin_n} = 2'h3;
        arst_n = 1'b0;
        cyc(4);
        arst_n = 1'b1;
        cyc(2);
        chk({out_pin_oe, bio_pin_oe}, 0);
        chk(out_rdata, 4'hF);
        chk({out_pin_pullup, bio_pin_pullup}, 0);
        chk(ctl_pin_pullup, 1);
        chk({b_out_pin_pullup, b_bio_pin_pullup}, 28'h00FF0F0);
        chk(b_out_pin_o, 16'h00FF);
        foreach (rows[i]) begin
            out_sel = rows[i][17:16];
            bio_sel = rows[i][17:16];
            out_wdata = rows[i][15:12];
            bio_wdata = rows[i][15:12];
            clamp = 12'(rows[i][11:8]) << (out_sel * 4);
            {out_wr, bio_wr} = 2'h3;
            cyc(1);
            {out_wr, bio_wr} = 2'h0;
            {out_rsel, bio_rsel} = {out_sel, out_sel};
            cyc(8);
            chk(out_rdata, rows[i][7:4]);
            chk(bio_rdata, rows[i][3:0]);
        end
        // output three read through bidir two pins under a clamp
        {bio_sel, bio_wdata, bio_wr, clamp} = {6'h2F, 1'b1, 12'h600};
        cyc(1);
        {bio_wr, out_rsel, bio_rsel} = 5'h0E;
        cyc(8);
        chk(out_rdata, 4'h9);
        chk(b_out_rdata, 4'hF);
        // held reset pin sets latches and blocks writes
        {out_sel, out_wdata, out_wr, clamp} = {6'h10, 1'b1, 12'h0};
        cyc(1);
        {out_wr, rst_pin_n} = 2'h0;
        k = 0;
        while (reset_req !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        if (k == 20) begin
            n_mismatch++;
            finish_test();
        end
        out_wr = 1'b1;
        cyc(2);
        out_wr = 1'b0;
        chk(out_pin_oe, 0);
        rst_pin_n = 1'b1;
        cyc(12);
        rst_pin_n = 1'b0;
        cyc(2);
        rst_pin_n = 1'b1;
        cyc(12);
        chk(reset_req, 0);
        // one pulse per long interrupt low, none for a short one
        k = 0;
        int_pin_n = 1'b0;
        cnt_int(6);
        int_pin_n = 1'b1;
        cnt_int(14);
        chk(k, 1);
        k = 0;
        int_pin_n = 1'b0;
        cnt_int(2);
        int_pin_n = 1'b1;
        cnt_int(14);
        chk(k, 0);
        finish_test();
    end
endmodule // tb_port_buffer_readback
`default_nettype wire
